// ---- src/jsr_map.vh ----
// constants for the scan register block: opcodes, chain layout, bus map
// assumes inclusion by jsr_scan_port.v and by the checker and testbench; definitions, no logic
`ifndef JSR_MAP_VH
`define JSR_MAP_VH
// ****************************************
// instruction register
// ****************************************
`define JSR_IR_W 16
`define JSR_CODE_W 8
`define JSR_IR_LOW 8'hFD
`define JSR_CODE_RESET 8'hEF
`define JSR_OP_EXTEST 4'h0
`define JSR_OP_CLAMP 4'h2
`define JSR_OP_HIGHZ 4'h3
`define JSR_OP_SAMPLE 4'h4
`define JSR_OP_RSTNEG 4'h6
`define JSR_OP_RSTASR 4'h7
`define JSR_OP_INTR 3'h5
`define JSR_OP_IDCODE 4'hE
`define JSR_OP_BYPASS 4'hF
// ****************************************
// data registers
// ****************************************
`define JSR_ID_W 32
`define JSR_BSR_LEN 333
`define JSR_NPIN 34
`define JSR_IN_HI 332
`define JSR_OUT_HI 298
`define JSR_CTL_HI 264
// ****************************************
// register map, byte addresses
// ****************************************
`define JSR_REG_INSTR 8'h00
`define JSR_REG_CTRL 8'h04
`define JSR_REG_STAT 8'h08
`define JSR_REG_LOG 8'h0C
`define JSR_CTRL_LOGEN 0
`define JSR_STAT_IRQ 0
`define JSR_STAT_RST 1
`define JSR_STAT_TAP_LO 4
`define JSR_STAT_CNT_LO 24
`define JSR_LOG_VALID 8
`define JSR_FIFO_DEPTH 8
`endif

// ---- src/jsr_scan_port.v ----
// scan port data registers, instruction decode, pad cells and log fifo
// assumes a 50 MHz clock; tck, tms, tdi, trstN and pads are asynchronous
// How it works
// - one bypass cell, invisible to software, reset value of no meaning
// - bypass instruction puts the single bypass cell between tdi and tdo
// - sixteen bit instruction register, read only to software, loaded by the port
// - test reset or test-logic-reset state forces the id code instruction
// - instruction loads never depend on any processor state; with logging on, a full log stalls them until software drains it
// - code sits in bits 15 to 8 and is shifted in from tdi
// - low byte reads 1111_1101 always
// - 0000 extest, 0010 clamp, 0011 highz, 0100 sample/preload
// - 1110 id code, 1111 bypass, 0110/0111 reset negate/assert, 101x interrupt
// - 333 cell boundary chain at the pads, invisible to software
// - boundary chain sits between tdi and tdo under the four boundary codes
// - cell 332 is nearest tdi; bidirectional pins have in, out, enable cells
// - first group inputs 332..299, outputs 298..265, enables 264..231
// - low test reset returns tap state, instruction code and tdo enable to reset without waiting for tck
// - tap state advances on tck by tms as in the standard state machine
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "jsr_map.vh"

// ****************************************
// log fifo
// ****************************************
module jsr_fifo #(
    parameter W = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clock,
    input wire arst_n,
    // filling side
    input wire inValid,
    input wire [W-1:0] inData,
    output wire inReady,
    // draining side
    output wire outValid,
    output wire [W-1:0] outData,
    input wire outReady,
    // fill level
    output wire [AW:0] count
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrIdx_r;
    reg [AW-1:0] rdIdx_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    // honest flags straight from the level
    assign inReady = (cnt_r != DEPTH[AW:0]);
    assign outValid = (cnt_r != {(AW+1){1'b0}});
    assign outData = mem[rdIdx_r];
    assign count = cnt_r;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // pointers wrap at the depth, which need not be a power of two
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrIdx_r <= {AW{1'b0}};
            rdIdx_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrIdx_r <= (wrIdx_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrIdx_r + 1'b1;
            end
            if (pop) begin
                rdIdx_r <= (rdIdx_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdIdx_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // storage has no reset; a read of an empty log shows an unwritten or stale slot
    always @(posedge clock) begin
        if (push) begin
            mem[wrIdx_r] <= inData;
        end
    end
endmodule

// ****************************************
// scan port top
// ****************************************
module jsr_scan_port #(
    parameter [`JSR_ID_W-1:0] ID_VALUE = 32'h00000001, // arbitrary value
    parameter NPIN = `JSR_NPIN
) (
    // clock and reset
    input wire clock,
    input wire arst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // test link pins
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trstN,
    output reg tdo,
    output reg tdoOe,
    // first pin group pads
    input wire [NPIN-1:0] padIn,
    output reg [NPIN-1:0] padOut,
    output reg [NPIN-1:0] padOe,
    // core side of the pads
    input wire [NPIN-1:0] coreOut,
    input wire [NPIN-1:0] coreOe,
    output reg [NPIN-1:0] coreIn,
    // requests to the core
    output reg coreRstReq,
    output reg dbgIrq
);
    // one-hot tap states
    localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004;
    localparam [15:0] S_CDR = 16'h0008, S_SHDR = 16'h0010, S_E1DR = 16'h0020;
    localparam [15:0] S_PDR = 16'h0040, S_E2DR = 16'h0080, S_UDR = 16'h0100;
    localparam [15:0] S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHIR = 16'h0800;
    localparam [15:0] S_E1IR = 16'h1000, S_PIR = 16'h2000, S_E2IR = 16'h4000;
    localparam [15:0] S_UIR = 16'h8000;

    // standard tap transitions
    function [15:0] tapNext;
        input [15:0] s;
        input m;
        begin
            case (s)
                S_TLR: tapNext = m ? S_TLR : S_RTI;
                S_RTI: tapNext = m ? S_SDR : S_RTI;
                S_SDR: tapNext = m ? S_SIR : S_CDR;
                S_CDR: tapNext = m ? S_E1DR : S_SHDR;
                S_SHDR: tapNext = m ? S_E1DR : S_SHDR;
                S_E1DR: tapNext = m ? S_UDR : S_PDR;
                S_PDR: tapNext = m ? S_E2DR : S_PDR;
                S_E2DR: tapNext = m ? S_UDR : S_SHDR;
                S_UDR: tapNext = m ? S_SDR : S_RTI;
                S_SIR: tapNext = m ? S_TLR : S_CIR;
                S_CIR: tapNext = m ? S_E1IR : S_SHIR;
                S_SHIR: tapNext = m ? S_E1IR : S_SHIR;
                S_E1IR: tapNext = m ? S_UIR : S_PIR;
                S_PIR: tapNext = m ? S_E2IR : S_PIR;
                S_E2IR: tapNext = m ? S_UIR : S_SHIR;
                S_UIR: tapNext = m ? S_SDR : S_RTI;
                default: tapNext = S_TLR;
            endcase
        end
    endfunction

    // boundary chain owns the data path for the four boundary codes
    function selBsr;
        input [3:0] op;
        begin
            selBsr = (op == `JSR_OP_EXTEST) || (op == `JSR_OP_CLAMP) ||
                (op == `JSR_OP_HIGHZ) || (op == `JSR_OP_SAMPLE);
        end
    endfunction

    // ****************************************
    // synchronisers and tck edges
    // ****************************************
    reg tckS1_r, tckS2_r, tckD_r;
    reg tmsS1_r, tmsS2_r, tdiS1_r, tdiS2_r;
    reg trstS1_r, trstS2_r;
    reg [NPIN-1:0] padS1_r, padS2_r;
    wire tckRise = tckS2_r & ~tckD_r;
    wire tckFall = ~tckS2_r & tckD_r;
    wire tapRst = ~trstS2_r;

    // tms and tdi share tck's latency, so they line up with its edges
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tckS1_r <= 1'b0;
            tckS2_r <= 1'b0;
            tckD_r <= 1'b0;
            tmsS1_r <= 1'b1;
            tmsS2_r <= 1'b1;
            tdiS1_r <= 1'b0;
            tdiS2_r <= 1'b0;
            trstS1_r <= 1'b0;
            trstS2_r <= 1'b0;
            padS1_r <= {NPIN{1'b0}};
            padS2_r <= {NPIN{1'b0}};
        end else begin
            tckS1_r <= tck;
            tckS2_r <= tckS1_r;
            tckD_r <= tckS2_r;
            tmsS1_r <= tms;
            tmsS2_r <= tmsS1_r;
            tdiS1_r <= tdi;
            tdiS2_r <= tdiS1_r;
            trstS1_r <= trstN;
            trstS2_r <= trstS1_r;
            padS1_r <= padIn;
            padS2_r <= padS1_r;
        end
    end

    // ****************************************
    // tap, instruction and data registers
    // ****************************************
    reg [15:0] tap_r;
    reg [`JSR_CODE_W-1:0] code_r;
    reg [`JSR_IR_W-1:0] irShift_r;
    reg bypass_r;
    reg [`JSR_ID_W-1:0] idShift_r;
    reg [`JSR_BSR_LEN-1:0] bsrShift_r;
    reg [`JSR_BSR_LEN-1:0] bsrUpd_r;
    reg logPend_r;
    reg [`JSR_CODE_W-1:0] logData_r;
    reg ctrlLogEn_r;
    wire fifoInReady;
    wire [3:0] op = code_r[7:4];
    wire isBsr = selBsr(op);
    wire isId = (op == `JSR_OP_IDCODE);
    // a full log stalls the port until software drains it
    wire stall = logPend_r & ~fifoInReady;
    wire step = tckRise & ~stall;
    wire [`JSR_IR_W-1:0] irView = {code_r, `JSR_IR_LOW};
    integer k, p;

    // test reset clears state at once, without a tck edge
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tap_r <= S_TLR;
            code_r <= `JSR_CODE_RESET;
        end else if (tapRst) begin
            tap_r <= S_TLR;
            code_r <= `JSR_CODE_RESET;
        end else if (step) begin
            tap_r <= tapNext(tap_r, tmsS2_r);
            if (tap_r == S_TLR) begin
                code_r <= `JSR_CODE_RESET;
            end else if (tap_r == S_UIR) begin
                // this load goes through at once; with the log full, the pending entry then stalls the following tck edges, through step, until software drains it
                code_r <= irShift_r[15:8];
            end
        end
    end

    // instruction shift path, code arrives from tdi into the top bits
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irShift_r <= {`JSR_CODE_RESET, `JSR_IR_LOW};
        end else if (step && tap_r == S_CIR) begin
            irShift_r <= irView;
        end else if (step && tap_r == S_SHIR) begin
            irShift_r <= {tdiS2_r, irShift_r[`JSR_IR_W-1:1]};
        end
    end

    // data shift paths: tdi enters cell 332, tdo leaves from cell 0
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bypass_r <= 1'b0;
            idShift_r <= {`JSR_ID_W{1'b0}};
            bsrShift_r <= {`JSR_BSR_LEN{1'b0}};
        end else if (step && tap_r == S_CDR) begin
            bypass_r <= 1'b0;
            idShift_r <= ID_VALUE;
            if (isBsr) begin
                for (k = 0; k < NPIN; k = k + 1) begin
                    bsrShift_r[`JSR_IN_HI - k] <= padS2_r[k];
                    bsrShift_r[`JSR_OUT_HI - k] <= padOut[k];
                    bsrShift_r[`JSR_CTL_HI - k] <= padOe[k];
                end
            end
        end else if (step && tap_r == S_SHDR) begin
            if (isBsr) begin
                bsrShift_r <= {tdiS2_r, bsrShift_r[`JSR_BSR_LEN-1:1]};
            end else if (isId) begin
                idShift_r <= {tdiS2_r, idShift_r[`JSR_ID_W-1:1]};
            end else begin
                bypass_r <= tdiS2_r;
            end
        end
    end

    // update latches only move in update-dr, so pads stay still while shifting
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bsrUpd_r <= {`JSR_BSR_LEN{1'b0}};
        end else if (step && tap_r == S_UDR && isBsr) begin
            bsrUpd_r <= bsrShift_r;
        end
    end

    // tdo changes on the falling tck edge, driven only while shifting
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tapRst) begin
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdoOe <= (tap_r == S_SHIR) || (tap_r == S_SHDR);
            if (tap_r == S_SHIR) begin
                tdo <= irShift_r[0];
            end else if (isBsr) begin
                tdo <= bsrShift_r[0];
            end else if (isId) begin
                tdo <= idShift_r[0];
            end else begin
                tdo <= bypass_r;
            end
        end
    end

    // pad muxing: boundary values drive pins under extest and clamp
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            padOut <= {NPIN{1'b0}};
            padOe <= {NPIN{1'b0}};
            coreIn <= {NPIN{1'b0}};
        end else begin
            coreIn <= padS2_r;
            for (p = 0; p < NPIN; p = p + 1) begin
                if (op == `JSR_OP_EXTEST || op == `JSR_OP_CLAMP) begin
                    padOut[p] <= bsrUpd_r[`JSR_OUT_HI - p];
                    padOe[p] <= bsrUpd_r[`JSR_CTL_HI - p];
                end else if (op == `JSR_OP_HIGHZ) begin
                    padOut[p] <= coreOut[p];
                    padOe[p] <= 1'b0;
                end else begin
                    padOut[p] <= coreOut[p];
                    padOe[p] <= coreOe[p];
                end
            end
        end
    end

    // ****************************************
    // requests to the core and the log
    // ****************************************
    reg irqSticky_r;
    wire [3:0] fifoCount;
    wire fifoOutValid;
    wire [`JSR_CODE_W-1:0] fifoOutData;
    wire apbDone = psel & penable & pready;
    wire logPop = apbDone & ~pwrite & (paddr == `JSR_REG_LOG) & fifoOutValid;
    wire updIr = step & (tap_r == S_UIR) & ~tapRst;
    wire [3:0] newOp = irShift_r[15:12];
    wire irqCmd = updIr & (newOp[3:1] == `JSR_OP_INTR);
    wire irqClr = apbDone & pwrite & (paddr == `JSR_REG_STAT) & pwdata[`JSR_STAT_IRQ];

    // reset and interrupt commands act as they become active
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            coreRstReq <= 1'b0;
            dbgIrq <= 1'b0;
            irqSticky_r <= 1'b0;
            logPend_r <= 1'b0;
            logData_r <= {`JSR_CODE_W{1'b0}};
        end else begin
            dbgIrq <= irqCmd;
            if (updIr && newOp == `JSR_OP_RSTASR) begin
                coreRstReq <= 1'b1;
            end else if (updIr && newOp == `JSR_OP_RSTNEG) begin
                coreRstReq <= 1'b0;
            end
            // a new request beats a clear in the same cycle
            if (irqCmd) begin
                irqSticky_r <= 1'b1;
            end else if (irqClr) begin
                irqSticky_r <= 1'b0;
            end
            if (updIr && ctrlLogEn_r) begin
                logPend_r <= 1'b1;
                logData_r <= irShift_r[15:8];
            end else if (fifoInReady) begin
                logPend_r <= 1'b0;
            end
        end
    end

    jsr_fifo #(
        .W(`JSR_CODE_W),
        .DEPTH(`JSR_FIFO_DEPTH),
        .AW(3)
    ) logFifo (
        .clock(clock),
        .arst_n(arst_n),
        .inValid(logPend_r),
        .inData(logData_r),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(logPop),
        .count(fifoCount)
    );

    // ****************************************
    // apb slave
    // ****************************************
    reg [31:0] rdMux;

    // read view; instruction register is read only
    always @* begin
        rdMux = 32'h00000000;
        case (paddr)
            `JSR_REG_INSTR: rdMux[`JSR_IR_W-1:0] = irView;
            `JSR_REG_CTRL: rdMux[`JSR_CTRL_LOGEN] = ctrlLogEn_r;
            `JSR_REG_STAT: begin
                rdMux[`JSR_STAT_IRQ] = irqSticky_r;
                rdMux[`JSR_STAT_RST] = coreRstReq;
                rdMux[`JSR_STAT_TAP_LO +: 16] = tap_r;
                rdMux[`JSR_STAT_CNT_LO +: 4] = fifoCount;
            end
            `JSR_REG_LOG: begin
                rdMux[`JSR_CODE_W-1:0] = fifoOutData;
                rdMux[`JSR_LOG_VALID] = fifoOutValid;
            end
            default: rdMux = 32'h00000000;
        endcase
    end

    // answer in the first access cycle; data latched in the setup cycle
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            ctrlLogEn_r <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                prdata <= rdMux;
                pslverr <= (paddr != `JSR_REG_INSTR) && (paddr != `JSR_REG_CTRL) &&
                    (paddr != `JSR_REG_STAT) && (paddr != `JSR_REG_LOG);
            end else begin
                pslverr <= 1'b0;
            end
            if (apbDone && pwrite && paddr == `JSR_REG_CTRL) begin
                ctrlLogEn_r <= pwdata[`JSR_CTRL_LOGEN];
            end
        end
    end
endmodule

// ---- verif/jsr_scan_port_sva.sv ----
// checker for the scan port: bus timing, fixed fields, pad modes, pulses
// assumes it is bound onto jsr_scan_port and sees only its ports
`timescale 1ns/1ns
`include "jsr_map.vh"
module jsr_scan_port_sva #(
    parameter NPIN = 34
) (
    // clock and reset
    input logic clock,
    input logic arst_n,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // link, pads, requests
    input logic trstN,
    input logic tdoOe,
    input logic [NPIN-1:0] padOut,
    input logic [NPIN-1:0] padOe,
    input logic [NPIN-1:0] coreOut,
    input logic [NPIN-1:0] coreOe,
    input logic dbgIrq
);
    // ****************************************
    // helpers
    // ****************************************
    // completed read of the instruction word
    wire instrRd = psel && penable && pready && !pwrite && paddr == `JSR_REG_INSTR;
    wire [3:0] op = prdata[15:12];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_ready_answer: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (psel && penable && pready && paddr > `JSR_REG_LOG |-> pslverr)
        else $error("unmapped access without error");
    a_instr_fixed: assert property (instrRd |-> prdata[7:0] == `JSR_IR_LOW && prdata[31:16] == 16'h0000)
        else $error("instruction low byte wrong");
    a_highz_oe: assert property (instrRd && op == `JSR_OP_HIGHZ |-> padOe == '0)
        else $error("pads driven under high impedance code");
    a_pass_core: assert property (instrRd && (op == `JSR_OP_SAMPLE || op == `JSR_OP_BYPASS
        || op == `JSR_OP_IDCODE) |-> padOut == coreOut && padOe == coreOe)
        else $error("pads not passing core values");
    a_irq_pulse: assert property (dbgIrq |=> !dbgIrq)
        else $error("interrupt request longer than one cycle");
    a_trst_oe: assert property (!trstN [*4] |-> !tdoOe && !dbgIrq)
        else $error("output enable or request during test reset");
endmodule

// ---- verif/jsr_tester.sv ----
// tester model: drives the test link pins and shifts ir and dr frames
// assumes a free running bench clock; tck stands low between frames
`timescale 1ns/1ns
module jsr_tester (
    // bench clock
    input logic clock,
    // test link
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trstN,
    input logic tdo,
    // frame results
    output logic scanDone,
    output logic [332:0] scanOut
);
    // ****************************************
    // pin control
    // ****************************************
    // power up with test reset held low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trstN = 1'b0;
        scanDone = 1'b0;
    end
    // one 160 ns tck period, tdo taken just before the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clock);
        o = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
    // frame from idle or reset back to idle; bench only loads defined codes
    task automatic scan(input logic ir, input int n, input logic [332:0] din);
        logic o;
        int i;
        scanOut <= '0;
        tick(1'b0, ~tdi, o);
        tick(1'b1, ~tdi, o);
        if (ir)
            tick(1'b1, ~tdi, o);
        tick(1'b0, ~tdi, o);
        tick(1'b0, ~tdi, o);
        for (i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            scanOut[i] <= o;
        end
        tick(1'b1, ~tdi, o);
        tick(1'b0, ~tdi, o);
        tck <= 1'b0;
        tdi <= ~tdi; // released line: no stale value
        scanDone <= 1'b1;
        @(posedge clock);
        scanDone <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
    // test reset pulse, no tck edges
    task automatic pulse_reset();
        trstN <= 1'b0;
        repeat (10) @(posedge clock);
        trstN <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    // five tms highs reach test-logic-reset from anywhere
    task automatic to_reset();
        logic o;
        repeat (5) tick(1'b1, ~tdi, o);
        tck <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ---- verif/jsr_scan_port_tb.sv ----
// testbench for the scan port: apb master, tester model, two scoreboards
// assumes jsr_tester and jsr_scan_port_sva are compiled before it
`timescale 1ns/1ns
`include "jsr_map.vh"
module jsr_scan_port_tb;
    localparam [31:0] ID = 32'h00000001; // arbitrary value
    localparam int N = 34;
    logic clock, arst_n, psel, penable, pwrite, tck, tms, tdi, trstN, tdo, tdoOe;
    logic pready, pslverr, coreRstReq, dbgIrq, scanDone, rq = 1'b0;
    logic [7:0] paddr, c, prev;
    logic [31:0] pwdata, prdata;
    logic [N-1:0] padIn, padOut, padOe, coreOut, coreOe, coreIn;
    logic [332:0] scanOut, pre, ex, mk;
    logic [63:0] qa[$];
    logic [332:0] qsExp[$], qsMask[$];
    logic [7:0] codes[9] = '{8'h00, 8'h20, 8'h30, 8'h40, 8'h70, 8'h60, 8'hA0, 8'hE0, 8'hF0};
    int n_errors = 0, comparisons = 0, i, k;

    jsr_scan_port #(.ID_VALUE(ID), .NPIN(N)) dut (.clock(clock), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms),
        .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .coreOut(coreOut), .coreOe(coreOe),
        .coreIn(coreIn), .coreRstReq(coreRstReq), .dbgIrq(dbgIrq));
    jsr_tester tst (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
        .tdo(tdo), .scanDone(scanDone), .scanOut(scanOut));

    // ****************************************
    // clock, compare, transfers
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk(input logic [332:0] g, input logic [332:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // request stands until ready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        qa.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask
    // capture shows the previous code first
    task automatic ir(input logic [7:0] code);
        qsExp.push_back({prev, 8'hFD});
        qsMask.push_back(333'hFFFF);
        tst.scan(1'b1, 16, {code, 8'hFD});
        prev = code;
    endtask
    task automatic dr(input int n, input logic [332:0] d, e, m);
        qsExp.push_back(e & m);
        qsMask.push_back(m);
        tst.scan(1'b0, n, d);
    endtask
    // results against the oldest notes
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk(prdata & qa[0][63:32], qa[0][31:0]);
            chk(pslverr, paddr > `JSR_REG_LOG);
            void'(qa.pop_front());
        end
        if (scanDone === 1'b1) begin
            chk(scanOut & qsMask[0], qsExp[0]);
            void'(qsExp.pop_front());
            void'(qsMask.pop_front());
        end
    end
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h4c56));
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        padIn = N'({$urandom, $urandom});
        coreOut = N'({$urandom, $urandom});
        coreOe = N'({$urandom, $urandom});
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        tst.pulse_reset();
        prev = 8'hEF;
        // reset word, write to a read-only word, unmapped place
        rd(`JSR_REG_INSTR, 32'h0000EFFD, 32'hFFFFFFFF);
        apb(1'b1, `JSR_REG_INSTR, 32'h00001200);
        rd(`JSR_REG_INSTR, 32'h0000EFFD, 32'hFFFFFFFF);
        rd(`JSR_REG_CTRL, 32'h0, 32'hFFFFFFFF);
        rd(`JSR_REG_LOG, 32'h0, 32'h100);
        rd(8'h10, 32'h0, 32'h0);
        // every defined code with random ignored bits
        for (i = 0; i < 9; i++) begin
            c = codes[i] | (8'($urandom) & (codes[i] == 8'hA0 ? 8'h1F : 8'h0F));
            ir(c);
            rd(`JSR_REG_INSTR, {16'h0, c, 8'hFD}, 32'hFFFFFFFF);
            rq = (c[7:4] == 4'h7) ? 1'b1 : (c[7:4] == 4'h6) ? 1'b0 : rq;
            rd(`JSR_REG_STAT, {30'h0, rq, c[7:5] == 3'b101}, 32'h3);
            chk(coreRstReq, rq);
            apb(1'b1, `JSR_REG_STAT, 32'h1);
        end
        // bypass cell captures 0, then delays tdi by one
        pre = 333'($urandom);
        dr(8, pre, {pre[6:0], 1'b0}, 333'hFF);
        ir(8'hE0);
        dr(32, pre, ID, 333'hFFFFFFFF);
        // sample/preload captures pads, then extest and clamp drive preload
        for (k = 0; k < 333; k++)
            pre[k] = 1'($urandom);
        ex = '0;
        mk = '0;
        for (k = 0; k < N; k++) begin
            ex[332 - k] = padIn[k];
            ex[298 - k] = coreOut[k];
            ex[264 - k] = coreOe[k];
            mk[332 - k] = 1'b1;
            mk[298 - k] = 1'b1;
            mk[264 - k] = 1'b1;
        end
        ir(8'h40);
        dr(333, pre, ex, mk);
        chk(coreIn, padIn);
        for (i = 0; i < 2; i++) begin
            ir(i ? 8'h20 : 8'h00);
            for (k = 0; k < N; k++) begin
                chk(padOut[k], pre[298 - k]);
                chk(padOe[k], pre[264 - k]);
            end
        end
        tst.pulse_reset();
        prev = 8'hEF;
        rd(`JSR_REG_INSTR, 32'h0000EFFD, 32'hFFFFFFFF);
        // log holds eight plus one pending; a tenth load is lost
        apb(1'b1, `JSR_REG_CTRL, 32'h1);
        for (i = 0; i < 9; i++)
            ir(codes[i]);
        rd(`JSR_REG_STAT, 32'h08000000, 32'h0F000000);
        qsExp.push_back('0);
        qsMask.push_back('0);
        tst.scan(1'b1, 16, {8'hE0, 8'hFD});
        for (i = 0; i < 9; i++)
            rd(`JSR_REG_LOG, {23'h0, 1'b1, codes[i]}, 32'h1FF);
        rd(`JSR_REG_LOG, 32'h0, 32'h100);
        apb(1'b1, `JSR_REG_CTRL, 32'h0);
        tst.to_reset();
        rd(`JSR_REG_INSTR, 32'h0000EFFD, 32'hFFFFFFFF);
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule

bind jsr_scan_port jsr_scan_port_sva #(.NPIN(NPIN)) sva (.clock(clock), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trstN(trstN), .tdoOe(tdoOe), .padOut(padOut),
    .padOe(padOe), .coreOut(coreOut), .coreOe(coreOe), .dbgIrq(dbgIrq));
